/* lvd_defs.vh */
`ifndef LVD_DEFS_VH
`define LVD_DEFS_VH

// Control register layout
`define LVD_CTRL_ON_BIT     7
`define LVD_CTRL_SRC_BIT    2
`define LVD_CTRL_ACT_BIT    1
`define LVD_CTRL_FLAG_BIT   0
`define LVD_CTRL_WMASK      8'h86
`define LVD_CTRL_RST        8'h00

// Level select register layout
`define LVD_LVL_SEL_BIT     0
`define LVD_LVL_WMASK       8'h01
`define LVD_LVL_RST         8'h00

// Reset cause register layout
`define LVD_CAUSE_LVD_BIT   0
`define LVD_CAUSE_RST       8'h00

// Source and action encodings
`define LVD_SRC_SUPPLY      1'b0
`define LVD_SRC_EXT_PIN     1'b1
`define LVD_ACT_IRQ         1'b0
`define LVD_ACT_RESET       1'b1

// Synchroniser depth
`define LVD_SYNC_STAGES     2

`endif

/* lvd_sync.v */
`timescale 1ns/1ps
`include "lvd_defs.vh"

module lvd_sync #(
   parameter W = 2
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         rst_b,
   // Asynchronous in, synchronous out
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // lvd_sync

/* lvd_ctrl.v */
`timescale 1ns/1ps
`include "lvd_defs.vh"

module lvd_ctrl (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst_b,
   // Watchdog reset: clears control, keeps reset cause
   input  wire       wdt_rst_req,
   // Control register access
   input  wire       ctrl_wr,
   input  wire [7:0] ctrl_wdata,
   output wire [7:0] ctrl_rdata,
   // Level select register access
   input  wire       lvl_wr,
   input  wire [7:0] lvl_wdata,
   output wire [7:0] lvl_rdata,
   // Reset cause register access, read clears
   input  wire       cause_rd,
   output wire [7:0] cause_rdata,
   // Analog comparator side
   input  wire       cmp_supply_below,
   input  wire       cmp_ext_below,
   output wire       cmp_enable,
   output wire       cmp_level_sel,
   // Responses
   output reg        lowvolt_interrupt,
   output reg        irq_req_flag,
   input  wire       irq_req_clr,
   output reg        lvd_reset_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg        detector_on_q;
   reg        action_select_q;
   reg        input_source_select_q;
   reg        level_select_q;
   reg        lowvolt_reset_cause_flag_q;
   reg        below_threshold_flag_q;
   reg        detector_on_d;
   reg        action_select_d;

   wire [1:0] cmp_sync;
   wire       sel_below;
   wire       below_d;
   wire       lvd_reset_d;
   wire       cause_set;

   // Pack one bit at its register position
   function [7:0] lvd_bit;
      input integer pos;
      input       val;
      begin
         lvd_bit = {7'h00, val} << pos;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Comparator synchronisation

   lvd_sync #(
      .W        (2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .async_in ({cmp_ext_below, cmp_supply_below}),
      .sync_out (cmp_sync)
   );

   assign sel_below = (input_source_select_q == `LVD_SRC_EXT_PIN) ? cmp_sync[1] : cmp_sync[0];

   assign below_d = detector_on_d & sel_below;

   assign cmp_level_sel = level_select_q & (input_source_select_q == `LVD_SRC_SUPPLY);

   assign cmp_enable = detector_on_q;

   ////////////////////////////////////////////////////////////////////////////
   // Next control values

   // Detection follows the control bits that take effect at this edge, except the source bit, so the
   // flag never reads 1 once the detector is off.
   always @*
   begin
      detector_on_d   = detector_on_q;
      action_select_d = action_select_q;
      if (wdt_rst_req)
      begin
         detector_on_d   = 1'b0;
         action_select_d = 1'b0;
      end
      else if (ctrl_wr)
      begin
         detector_on_d   = ctrl_wdata[`LVD_CTRL_ON_BIT];
         action_select_d = ctrl_wdata[`LVD_CTRL_ACT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and level registers

   // Only rst_b and the watchdog clear these; the reset this block drives
   // out never reaches them, so configuration survives a detector reset.
   // retention over detector reset
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         detector_on_q         <= 1'b0;
         action_select_q       <= 1'b0;
         input_source_select_q <= 1'b0;
      end
      else if (wdt_rst_req)
      begin
         detector_on_q         <= 1'b0;
         action_select_q       <= 1'b0;
         input_source_select_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         detector_on_q         <= ctrl_wdata[`LVD_CTRL_ON_BIT];
         action_select_q       <= ctrl_wdata[`LVD_CTRL_ACT_BIT];
         input_source_select_q <= ctrl_wdata[`LVD_CTRL_SRC_BIT];
      end
   end

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         level_select_q <= 1'b0;
      else if (wdt_rst_req)
         level_select_q <= 1'b0;
      else if (lvl_wr)
         level_select_q <= lvl_wdata[`LVD_LVL_SEL_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Detection and responses

   assign lvd_reset_d = below_d & (action_select_d == `LVD_ACT_RESET);

   // all on clk_sys, which must stay running in STOP
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         below_threshold_flag_q <= 1'b0;
         lvd_reset_req          <= 1'b0;
         lowvolt_interrupt      <= 1'b0;
      end
      else
      begin
         below_threshold_flag_q <= below_d;
         lvd_reset_req          <= lvd_reset_d;
         // pulse on each edge of the flag while the next action select is interrupt
         // switching off while below drops the flag and fires too
         lowvolt_interrupt      <= (below_d != below_threshold_flag_q) &
                                   (action_select_d == `LVD_ACT_IRQ);
      end
   end

   // Set wins so a pulse in the clearing cycle is not lost
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         irq_req_flag <= 1'b0;
      else if (lowvolt_interrupt)
         irq_req_flag <= 1'b1;
      else if (irq_req_clr)
         irq_req_flag <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause

   assign cause_set = lvd_reset_req;

   // cause flag set by detector reset, held over watchdog reset
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         lowvolt_reset_cause_flag_q <= 1'b0;
      else if (cause_set)
         lowvolt_reset_cause_flag_q <= 1'b1;
      else if (cause_rd)
         lowvolt_reset_cause_flag_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   assign ctrl_rdata = lvd_bit(`LVD_CTRL_ON_BIT, detector_on_q)
                     | lvd_bit(`LVD_CTRL_SRC_BIT, input_source_select_q)
                     | lvd_bit(`LVD_CTRL_ACT_BIT, action_select_q)
                     | lvd_bit(`LVD_CTRL_FLAG_BIT, below_threshold_flag_q);

   assign lvl_rdata   = lvd_bit(`LVD_LVL_SEL_BIT, level_select_q);
   assign cause_rdata = lvd_bit(`LVD_CAUSE_LVD_BIT, lowvolt_reset_cause_flag_q);

endmodule // lvd_ctrl

/* lvd_chk_assertions.sv */
`timescale 1ns/1ps
module lvd_chk (
   // Clock and reset
   input wire       clk_sys,
   input wire       rst_b,
   // Observed outputs
   input wire [7:0] ctrl_rdata,
   input wire [7:0] lvl_rdata,
   input wire [7:0] cause_rdata,
   input wire       cmp_enable,
   input wire       cmp_level_sel,
   input wire       lowvolt_interrupt,
   input wire       irq_req_flag,
   input wire       lvd_reset_req
);
   ////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_CMP_ON: assert property (cmp_enable == ctrl_rdata[7])
      else $error("comparator enable differs");
   AST_LVL_SEL: assert property (cmp_level_sel == (lvl_rdata[0] & !ctrl_rdata[2]))
      else $error("level select output wrong");
   AST_OFF_FLAG: assert property (!ctrl_rdata[7] |-> !ctrl_rdata[0])
      else $error("flag set while off");
   AST_PULSE: assert property (lowvolt_interrupt |=> !lowvolt_interrupt)
      else $error("interrupt longer than one cycle");
   AST_IRQ_CHG: assert property (lowvolt_interrupt |-> $changed(ctrl_rdata[0]))
      else $error("interrupt without flag change");
   AST_NO_IRQ: assert property (ctrl_rdata[1] && $past(ctrl_rdata[1]) |-> !lowvolt_interrupt)
      else $error("interrupt in reset mode");
   AST_RST_SRC: assert property ($rose(lvd_reset_req) |-> ctrl_rdata[1:0] == 2'b11)
      else $error("reset request without cause");
   AST_CAUSE: assert property (lvd_reset_req |=> cause_rdata[0])
      else $error("cause flag not set");
   AST_IRQ_SET: assert property (lowvolt_interrupt |=> irq_req_flag)
      else $error("request flag not set");
endmodule // lvd_chk

bind lvd_ctrl lvd_chk u_lvd_chk (.clk_sys, .rst_b, .ctrl_rdata, .lvl_rdata, .cause_rdata, .cmp_enable,
   .cmp_level_sel, .lowvolt_interrupt, .irq_req_flag, .lvd_reset_req);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic       clk_sys          = 1'b0;
   logic       rst_b            = 1'b0;
   logic       wdt_rst_req      = 1'b0;
   logic       ctrl_wr          = 1'b0;
   logic       lvl_wr           = 1'b0;
   logic       cause_rd         = 1'b0;
   logic       cmp_supply_below = 1'b0;
   logic       cmp_ext_below    = 1'b0;
   logic       irq_req_clr      = 1'b0;
   logic [7:0] ctrl_wdata       = 8'h00;
   logic [7:0] lvl_wdata        = 8'h00;
   wire  [7:0] ctrl_rdata;
   wire  [7:0] lvl_rdata;
   wire  [7:0] cause_rdata;
   wire        cmp_enable;
   wire        cmp_level_sel;
   wire        lowvolt_interrupt;
   wire        irq_req_flag;
   wire        lvd_reset_req;
   int         miscompares      = 0;
   int         cmp_count        = 0;
   ////////////////////////////////////////
   lvd_ctrl u_lvd_ctrl (.clk_sys, .rst_b, .wdt_rst_req, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .lvl_wr,
      .lvl_wdata, .lvl_rdata, .cause_rd, .cause_rdata, .cmp_supply_below, .cmp_ext_below, .cmp_enable,
      .cmp_level_sel, .lowvolt_interrupt, .irq_req_flag, .irq_req_clr, .lvd_reset_req);
   always #5 clk_sys = ~clk_sys;
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Strobe is taken at the second edge
   task wr(input bit lvl, input logic [7:0] d);
      @(posedge clk_sys);
      if (lvl)
      begin
         lvl_wr    <= 1'b1;
         lvl_wdata <= d;
      end
      else
      begin
         ctrl_wr    <= 1'b1;
         ctrl_wdata <= d;
      end
      @(posedge clk_sys);
      ctrl_wr <= 1'b0;
      lvl_wr  <= 1'b0;
      #1;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Tests need well under 100 cycles; 2000 cycles means a hang
   initial
   begin
      #20000;
      miscompares++;
      give_verdict;
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      wt(1);
      chk("ctrl", ctrl_rdata, 8'h00);
      chk("lvl", lvl_rdata, 8'h00);
      chk("cmp en", cmp_enable, 8'h00);
      chk("cause", cause_rdata, 8'h00);
      $display("test reset done");
      wr(0, 8'h80);
      chk("cmp en", cmp_enable, 8'h01);
      wr(1, 8'hFF);
      chk("lvl", lvl_rdata, 8'h01);
      chk("lvlsel", cmp_level_sel, 8'h01);
      @(posedge clk_sys) cmp_supply_below <= 1'b1;
      wt(3);
      chk("flag", ctrl_rdata, 8'h81);
      chk("irq", lowvolt_interrupt, 8'h01);
      wt(1);
      chk("irqflag", irq_req_flag, 8'h01);
      chk("irq end", lowvolt_interrupt, 8'h00);
      wr(0, 8'h84);
      chk("lvlsel", cmp_level_sel, 8'h00);
      wt(1);
      chk("ext flag", ctrl_rdata, 8'h84);
      @(posedge clk_sys) cmp_ext_below <= 1'b1;
      wt(3);
      chk("ext flag", ctrl_rdata, 8'h85);
      chk("ext irq", lowvolt_interrupt, 8'h01);
      @(posedge clk_sys) irq_req_clr <= 1'b1;
      @(posedge clk_sys) irq_req_clr <= 1'b0;
      wt(1);
      chk("irqclr", irq_req_flag, 8'h00);
      wr(0, 8'h00);
      chk("off irq", lowvolt_interrupt, 8'h01);
      chk("off flag", ctrl_rdata, 8'h00);
      chk("off cmp en", cmp_enable, 8'h00);
      wt(1);
      chk("off irqflag", irq_req_flag, 8'h01);
      $display("test interrupt done");
      wr(0, 8'h86);
      chk("rst no irq", lowvolt_interrupt, 8'h00);
      wt(3);
      chk("rstreq", lvd_reset_req, 8'h01);
      chk("cause", cause_rdata, 8'h01);
      chk("held", ctrl_rdata, 8'h87);
      chk("lvl held", lvl_rdata, 8'h01);
      @(posedge clk_sys) cmp_ext_below <= 1'b0;
      wt(4);
      chk("rstrel", lvd_reset_req, 8'h00);
      @(posedge clk_sys) wdt_rst_req <= 1'b1;
      @(posedge clk_sys) wdt_rst_req <= 1'b0;
      #1;
      chk("wdt ctrl", ctrl_rdata, 8'h00);
      chk("wdt lvl", lvl_rdata, 8'h00);
      chk("wdt cause", cause_rdata, 8'h01);
      @(posedge clk_sys) cause_rd <= 1'b1;
      @(posedge clk_sys) cause_rd <= 1'b0;
      wt(1);
      chk("cause rd", cause_rdata, 8'h00);
      $display("test reset mode done");
      wr(0, 8'h80);
      wr(1, 8'h01);
      chk("pre por", ctrl_rdata, 8'h81);
      @(posedge clk_sys) rst_b <= 1'b0;
      @(posedge clk_sys) rst_b <= 1'b1;
      wt(1);
      chk("por ctrl", ctrl_rdata, 8'h00);
      chk("por lvl", lvl_rdata, 8'h00);
      chk("por cmp en", cmp_enable, 8'h00);
      $display("test pin reset done");
      give_verdict;
   end
endmodule // tb_top
